// >>> hdl/ssf_status.sv
// Status-flag register bank of the SCSI controller with AXI4-Lite access
`timescale 1ns/1ps
`include "ssf_consts.svh"

// What this block does
// R1: Disconnect flag only in initiator mode
// R2: Scripts: disconnect unexpected unless after 04/00
// R3: Low-level initiator mode: any disconnect flags
// R4: Reset flag from bus or own reset
// R5: Reset detected on edge, one event
// R6: SCSI parity error only when checking enabled
// R7: Host parity error needs enable, not pass-through
// R8: Input latch full while holding byte
// R9: Hidden buffer full while holding byte
// R10: Output latch full while holding byte
// R11: Arbitration in progress after free, BSY, ID
// R12: Lost arbitration when SEL seen
// R13: Won flag only in full arbitration mode
// R14: Live RST level readable
// R15: Live parity level readable
// R16: Status register writes are ignored
module ssf_status import ssf_pkg::*; (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           nrst,
    // AXI4-Lite slave
    input  wire logic [7:0]     s_axi_awaddr,
    input  wire logic           s_axi_awvalid,
    output logic                s_axi_awready,
    input  wire logic [31:0]    s_axi_wdata,
    input  wire logic [3:0]     s_axi_wstrb,
    input  wire logic           s_axi_wvalid,
    output logic                s_axi_wready,
    output logic [1:0]          s_axi_bresp,
    output logic                s_axi_bvalid,
    input  wire logic           s_axi_bready,
    input  wire logic [7:0]     s_axi_araddr,
    input  wire logic           s_axi_arvalid,
    output logic                s_axi_arready,
    output logic [31:0]         s_axi_rdata,
    output logic [1:0]          s_axi_rresp,
    output logic                s_axi_rvalid,
    input  wire logic           s_axi_rready,
    // SCSI bus levels and drivers
    input  wire ssf_scsi_in_t   scsi_in,
    output logic                bsy_o,
    output logic                bsy_oe,
    output logic [7:0]          data_o,
    output logic                data_oe,
    output logic                rst_o,
    output logic                rst_oe,
    // Controller core
    input  wire logic           initiator_mode,
    input  wire logic           scripts_running,
    input  wire logic           msg_in_valid,
    input  wire logic [7:0]     msg_in_byte,
    input  wire logic           disconnect_evt,
    input  wire logic           scsi_byte_valid,
    input  wire logic           host_byte_valid,
    input  wire logic [7:0]     host_byte,
    input  wire logic           host_par,
    input  wire ssf_latch_evt_t latch_evt,
    // Interrupt
    output logic                irq
);

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [7:0]  awaddr_q;
    logic [7:0]  wdata_q;
    logic        wlane_q;
    logic [7:0]  ctrl0_q;
    logic [7:0]  ctrl1_q;
    logic [`SSF_NIRQ-1:0] ist_q;
    logic [`SSF_NIRQ-1:0] imsk_q;
    logic        udc_q;
    logic        rstf_q;
    logic        par_q;
    logic        ifl_q;
    logic        orf_q;
    logic        olf_q;
    logic        loa_q;
    logic        woa_q;
    logic        aip_q;
    logic [7:0]  stat0;
    logic [7:0]  stat1;
    logic [7:0]  rbyte;
    logic        rmapped;
    logic        wr_go;
    logic        rd_go;
    logic        rd_clr0;
    logic        rd_clr1;
    logic        wmapped;

    assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign rd_clr0 = rd_go && (s_axi_araddr == `SSF_OFS_STAT0);
    assign rd_clr1 = rd_go && (s_axi_araddr == `SSF_OFS_STAT1);

    assign stat0 = {5'h00, udc_q, rstf_q, par_q};
    // Live bus levels go straight into the read word, unlatched [R14] [R15]
    assign stat1 = {ifl_q, orf_q, olf_q, aip_q, loa_q, woa_q, scsi_in.rst, scsi_in.sdp};

    always_comb begin
        rbyte = `SSF_RST_BYTE;
        rmapped = 1'b1;
        if (s_axi_araddr == `SSF_OFS_STAT0) begin
            rbyte = stat0;
        end else if (s_axi_araddr == `SSF_OFS_STAT1) begin
            rbyte = stat1;
        end else if (s_axi_araddr == `SSF_OFS_CTRL0) begin
            rbyte = ctrl0_q;
        end else if (s_axi_araddr == `SSF_OFS_CTRL1) begin
            rbyte = ctrl1_q;
        end else if (s_axi_araddr == `SSF_OFS_IST) begin
            rbyte = {3'h0, ist_q};
        end else if (s_axi_araddr == `SSF_OFS_IMSK) begin
            rbyte = {3'h0, imsk_q};
        end else begin
            rmapped = 1'b0;
        end
    end

    // Status offsets are mapped but writes to them do nothing [R16]
    assign wmapped = (awaddr_q == `SSF_OFS_STAT0) || (awaddr_q == `SSF_OFS_STAT1)
                  || (awaddr_q == `SSF_OFS_CTRL0) || (awaddr_q == `SSF_OFS_CTRL1)
                  || (awaddr_q == `SSF_OFS_IST) || (awaddr_q == `SSF_OFS_IMSK);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SSF_RESP_OK;
            awaddr_q      <= `SSF_RST_BYTE;
            wdata_q       <= `SSF_RST_BYTE;
            wlane_q       <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                awaddr_q      <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wdata_q      <= s_axi_wdata[7:0];
                wlane_q      <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wmapped ? `SSF_RESP_OK : `SSF_RESP_ERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `SSF_RESP_OK;
        end else if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h00_0000, rbyte};
            s_axi_rresp   <= rmapped ? `SSF_RESP_OK : `SSF_RESP_ERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic wr_ctrl0;
    logic wr_ctrl1;
    logic wr_ist;
    logic wr_imsk;
    logic arb_start;

    assign wr_ctrl0 = wr_go && wlane_q && (awaddr_q == `SSF_OFS_CTRL0);
    assign wr_ctrl1 = wr_go && wlane_q && (awaddr_q == `SSF_OFS_CTRL1);
    assign wr_ist   = wr_go && wlane_q && (awaddr_q == `SSF_OFS_IST);
    assign wr_imsk  = wr_go && wlane_q && (awaddr_q == `SSF_OFS_IMSK);
    assign arb_start = wr_ctrl1 && wdata_q[`SSF_C1_START];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl0_q <= `SSF_RST_BYTE;
            ctrl1_q <= `SSF_RST_BYTE;
            imsk_q  <= `SSF_RST_IRQ;
        end else begin
            if (wr_ctrl0) begin
                ctrl0_q <= wdata_q;
            end
            // Start bit is a trigger, never stored
            if (wr_ctrl1) begin
                ctrl1_q <= wdata_q & ~(8'h01 << `SSF_C1_START);
            end
            if (wr_imsk) begin
                imsk_q <= wdata_q[`SSF_NIRQ-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Disconnect, reset and parity events
    // ------------------------------------------------------------
    logic       clean_msg_q;
    logic       rst_seen_q;
    logic       rst_seen;
    logic       ev_udc;
    logic       ev_rst;
    logic       ev_par;
    logic       scsi_perr;
    logic       host_perr;
    logic       par_en;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            clean_msg_q <= 1'b0;
        end else if (disconnect_evt) begin
            clean_msg_q <= 1'b0;
        end else if (msg_in_valid) begin
            clean_msg_q <= (msg_in_byte == `SSF_MSG_DISC) || (msg_in_byte == `SSF_MSG_CC);
        end
    end

    // Target mode never flags; low-level initiator mode flags every disconnect [R1] [R2] [R3]
    assign ev_udc = disconnect_evt && initiator_mode && !(scripts_running && clean_msg_q);

    // Own reset drive counts as well as a foreign one [R4]
    assign rst_seen = scsi_in.rst || rst_oe;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_seen_q <= 1'b0;
        end else begin
            rst_seen_q <= rst_seen;
        end
    end
    // Edge, not level: a long reset raises one event [R5]
    assign ev_rst = rst_seen && !rst_seen_q;

    // Odd parity on both paths
    assign par_en    = ctrl0_q[`SSF_C0_PAREN];
    assign scsi_perr = scsi_byte_valid && !(^{scsi_in.data, scsi_in.sdp}); // [R6]
    assign host_perr = host_byte_valid && !ctrl0_q[`SSF_C0_PASSOFF]
                    && !(^{host_byte, host_par}); // [R7]
    assign ev_par    = par_en && (scsi_perr || host_perr); // [R6] [R7]

    // Status flags clear on read of their register; a same-cycle event wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            udc_q  <= 1'b0;
            rstf_q <= 1'b0;
            par_q  <= 1'b0;
        end else begin
            udc_q  <= ev_udc || (udc_q && !rd_clr0);  // [R1]
            rstf_q <= ev_rst || (rstf_q && !rd_clr0); // [R4]
            par_q  <= ev_par || (par_q && !rd_clr0);  // [R6]
        end
    end

    // ------------------------------------------------------------
    // Data-path latch occupancy
    // ------------------------------------------------------------
    // Load beats drain: a byte that replaces one leaves the latch full
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ifl_q <= 1'b0;
            orf_q <= 1'b0;
            olf_q <= 1'b0;
        end else begin
            ifl_q <= latch_evt.in_load || (ifl_q && !latch_evt.in_drain); // [R8]
            orf_q <= latch_evt.hid_load || (orf_q && !latch_evt.hid_move); // [R9]
            olf_q <= latch_evt.out_load || latch_evt.hid_move
                  || (olf_q && !latch_evt.out_drain); // [R10]
        end
    end

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    ssf_arb_state_t st_q;
    logic [8:0]     arb_cnt_q;
    logic [2:0]     own_id;
    logic [7:0]     higher;
    logic           bus_free;
    logic           arb_end;
    logic           ev_loa;
    logic           ev_woa;

    assign own_id   = ctrl1_q[`SSF_C1_ID_HI:`SSF_C1_ID_LO];
    assign higher   = ~((8'h02 << own_id) - 8'h01);
    assign bus_free = !scsi_in.bsy && !scsi_in.sel;
    assign arb_end  = (st_q == SSF_ARB) && (arb_cnt_q == 9'(`SSF_ARB_CYC - 1));
    assign ev_loa   = (st_q == SSF_ARB) && (scsi_in.sel
                   || (arb_end && ((scsi_in.data & higher) != 8'h00))); // [R12]
    assign ev_woa   = arb_end && !ev_loa
                   && (ctrl0_q[`SSF_C0_ARB_HI:`SSF_C0_ARB_LO] == `SSF_ARB_FULL); // [R13]

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q      <= SSF_IDLE;
            arb_cnt_q <= 9'h000;
        end else begin
            case (st_q)
                SSF_IDLE: begin
                    if (arb_start) begin
                        st_q <= SSF_WAIT_FREE;
                    end
                end
                SSF_WAIT_FREE: begin
                    arb_cnt_q <= 9'h000;
                    if (bus_free) begin
                        st_q <= SSF_ARB;
                    end
                end
                SSF_ARB: begin
                    arb_cnt_q <= arb_cnt_q + 9'h001;
                    if (ev_loa || arb_end) begin
                        st_q <= SSF_IDLE;
                    end
                end
                default: begin
                    st_q <= SSF_IDLE;
                end
            endcase
        end
    end

    // Bus drivers are all from flops; BSY and the data enable rise one cycle after ARB is entered and drop in the cycle the state leaves it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aip_q   <= 1'b0;
            bsy_o   <= 1'b0;
            bsy_oe  <= 1'b0;
            data_o  <= `SSF_RST_BYTE;
            data_oe <= 1'b0;
            rst_o   <= 1'b0;
            rst_oe  <= 1'b0;
        end else begin
            aip_q   <= (st_q == SSF_ARB) && !ev_loa && !arb_end; // [R11]
            bsy_o   <= (st_q == SSF_ARB) && !ev_loa && !arb_end;
            bsy_oe  <= (st_q == SSF_ARB) && !ev_loa && !arb_end;
            data_o  <= 8'h01 << own_id; // [R11]
            data_oe <= (st_q == SSF_ARB) && !ev_loa && !arb_end;
            rst_o   <= ctrl1_q[`SSF_C1_ARST];
            rst_oe  <= ctrl1_q[`SSF_C1_ARST];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            loa_q <= 1'b0;
            woa_q <= 1'b0;
        end else begin
            loa_q <= ev_loa || (loa_q && !rd_clr1 && !arb_start); // [R12]
            woa_q <= ev_woa || (woa_q && !rd_clr1 && !arb_start); // [R13]
        end
    end

    // ------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------
    logic [`SSF_NIRQ-1:0] ev_all;
    logic [`SSF_NIRQ-1:0] ist_clr;

    assign ev_all  = {ev_woa, ev_loa, ev_par, ev_rst, ev_udc};
    assign ist_clr = wr_ist ? wdata_q[`SSF_NIRQ-1:0] : `SSF_RST_IRQ;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ist_q <= `SSF_RST_IRQ;
            irq   <= 1'b0;
        end else begin
            ist_q <= ev_all | (ist_q & ~ist_clr);
            irq   <= |(ist_q & imsk_q);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_udc_cause: assert property (@(posedge clk) disable iff (!nrst) // [R1]
        $rose(udc_q) |-> $past(disconnect_evt && initiator_mode))
        else $error("disconnect flag without initiator disconnect");
    a_udc_clean_msg: assert property (@(posedge clk) disable iff (!nrst) // [R2]
        (disconnect_evt && scripts_running && clean_msg_q && !udc_q) |=> !udc_q)
        else $error("clean disconnect flagged");
    a_rst_edge_once: assert property (@(posedge clk) disable iff (!nrst) // [R5]
        (ev_rst ##1 (rst_seen && !rd_clr0)) |-> !ev_rst && rstf_q)
        else $error("reset edge detection wrong");
    a_par_gate: assert property (@(posedge clk) disable iff (!nrst) // [R6]
        $rose(par_q) |-> $past(par_en))
        else $error("parity flag while checking disabled");
    a_host_par_gate: assert property (@(posedge clk) disable iff (!nrst) // [R7]
        (host_byte_valid && ctrl0_q[`SSF_C0_PASSOFF] && !scsi_byte_valid) |-> !ev_par)
        else $error("host parity flagged in pass-through");
    a_ifl_track: assert property (@(posedge clk) disable iff (!nrst) // [R8]
        latch_evt.in_load |=> ifl_q)
        else $error("input latch flag missed load");
    a_aip_drive: assert property (@(posedge clk) disable iff (!nrst) // [R11]
        aip_q |-> bsy_oe && data_oe && (data_o == (8'h01 << own_id)))
        else $error("arbitration without bus drive");
    a_loa_sel: assert property (@(posedge clk) disable iff (!nrst) // [R12]
        (st_q == SSF_ARB && scsi_in.sel) |=> loa_q && st_q == SSF_IDLE)
        else $error("SEL during arbitration not lost");
    a_woa_mode: assert property (@(posedge clk) disable iff (!nrst) // [R13]
        $rose(woa_q) |-> $past((ctrl0_q[`SSF_C0_ARB_HI:`SSF_C0_ARB_LO] == `SSF_ARB_FULL)
                               && st_q == SSF_ARB))
        else $error("won flag outside full mode");
    a_ro_status: assert property (@(posedge clk) disable iff (!nrst) // [R16]
        (wr_go && awaddr_q == `SSF_OFS_STAT0 && ev_all == 5'h00 && !rd_clr0)
        |=> $stable(stat0))
        else $error("status write changed flags");
    a_irq_level: assert property (@(posedge clk) disable iff (!nrst)
        irq == $past(|(ist_q & imsk_q)))
        else $error("interrupt not following masked status");

    c_won: cover property (@(posedge clk) disable iff (!nrst) $rose(woa_q));
    c_lost: cover property (@(posedge clk) disable iff (!nrst) $rose(loa_q));
    c_rst: cover property (@(posedge clk) disable iff (!nrst) ev_rst);
    c_udc: cover property (@(posedge clk) disable iff (!nrst) ev_udc && irq);

endmodule

// >>> shared/ssf_consts.svh
// Register offsets, field positions and timing counts of the status-flag block
`ifndef SSF_CONSTS_SVH
`define SSF_CONSTS_SVH
// Register byte offsets
`define SSF_OFS_STAT0   8'h00
`define SSF_OFS_STAT1   8'h04
`define SSF_OFS_CTRL0   8'h08
`define SSF_OFS_CTRL1   8'h0c
`define SSF_OFS_IST     8'h10
`define SSF_OFS_IMSK    8'h14
// Status zero fields
`define SSF_S0_UDC      2
`define SSF_S0_RST      1
`define SSF_S0_PAR      0
// Control zero fields
`define SSF_C0_ARB_HI   7
`define SSF_C0_ARB_LO   6
`define SSF_C0_PAREN    3
`define SSF_C0_PASSOFF  2
`define SSF_ARB_FULL    2'h3
// Control one fields
`define SSF_C1_ID_HI    6
`define SSF_C1_ID_LO    4
`define SSF_C1_ARST     3
`define SSF_C1_START    0
// Interrupt bits
`define SSF_I_UDC       0
`define SSF_I_RST       1
`define SSF_I_PAR       2
`define SSF_I_LOA       3
`define SSF_I_WOA       4
`define SSF_NIRQ        5
// Message codes that end a connection cleanly
`define SSF_MSG_DISC    8'h04
`define SSF_MSG_CC      8'h00
// Reset values
`define SSF_RST_BYTE    8'h00
`define SSF_RST_IRQ     5'h00
// Timing
`define SSF_CLK_NS      8
`define SSF_ARB_NS      2400
`define SSF_ARB_CYC     ((`SSF_ARB_NS + `SSF_CLK_NS - 1) / `SSF_CLK_NS)
// AXI responses
`define SSF_RESP_OK     2'h0
`define SSF_RESP_ERR    2'h2
`endif

// >>> shared/ssf_pkg.sv
// Types shared by the status-flag block and its bench
package ssf_pkg;
    typedef struct packed {
        logic       rst;
        logic       sdp;
        logic       sel;
        logic       bsy;
        logic [7:0] data;
    } ssf_scsi_in_t;

    typedef struct packed {
        logic in_load;
        logic in_drain;
        logic hid_load;
        logic hid_move;
        logic out_load;
        logic out_drain;
    } ssf_latch_evt_t;

    typedef enum logic [1:0] {
        SSF_IDLE,
        SSF_WAIT_FREE,
        SSF_ARB
    } ssf_arb_state_t;
endpackage

// >>> tb/ssf_scsi_model.sv
// Far-side SCSI devices: wired bus levels seen by the status block
`timescale 1ns/1ps

module ssf_scsi_model import ssf_pkg::*; (
    // Bench commands for the other devices
    input  wire logic       rst_req,
    input  wire logic       sel_req,
    input  wire logic       byte_on,
    input  wire logic [7:0] byte_val,
    input  wire logic       bad_par,
    // Drivers of the block
    input  wire logic       bsy_o,
    input  wire logic       bsy_oe,
    input  wire logic [7:0] data_o,
    input  wire logic       data_oe,
    input  wire logic       rst_o,
    input  wire logic       rst_oe,
    // Wired bus levels
    output ssf_scsi_in_t    bus
);
    // Released lines fall back to deasserted through the terminators
    assign bus = {rst_req | (rst_oe & rst_o), byte_on & (~^byte_val ^ bad_par), sel_req,
                  bsy_oe & bsy_o, (byte_on ? byte_val : 8'h00) | (data_oe ? data_o : 8'h00)};
endmodule

// >>> tb/ssf_status_tb.sv
// Self-checking bench of the SCSI status-flag register bank
`timescale 1ns/1ps
`include "ssf_consts.svh"

module ssf_status_tb import ssf_pkg::*;;
    // ----
    // Stimulus and observation
    // ----
    logic           clk = 1'b0;
    logic           nrst = 1'b0;
    logic [7:0]     awa = 8'h00, ara = 8'h00, mbyte = 8'h00, hbyte = 8'h00, bval = 8'h00;
    logic [31:0]    wd = 32'h0;
    logic           awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, hpar = 0;
    logic           init = 0, scr = 0, mv = 0, disc = 0, sbv = 0, hbv = 0;
    logic           rreq = 0, sreq = 0, bon = 0, bad = 0;
    ssf_latch_evt_t lev = '0;
    ssf_scsi_in_t   bus;
    logic           awr, wrd, bvld, arr, rvld, bsy_o, bsy_oe, data_oe, rst_o, rst_oe, irq;
    logic [1:0]     bresp, rresp;
    logic [31:0]    rdata;
    logic [7:0]     data_o;
    int             err_total = 0;
    int             cmp_count = 0;
    int             cyc = 0;
    localparam logic [1:0] OK = `SSF_RESP_OK;
    localparam logic [1:0] ERR = `SSF_RESP_ERR;

    always #4 clk = ~clk;

    ssf_status i_ssf_status (
        .clk(clk), .nrst(nrst),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvld), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvld), .s_axi_rready(rry),
        .scsi_in(bus), .bsy_o(bsy_o), .bsy_oe(bsy_oe), .data_o(data_o), .data_oe(data_oe),
        .rst_o(rst_o), .rst_oe(rst_oe), .initiator_mode(init), .scripts_running(scr),
        .msg_in_valid(mv), .msg_in_byte(mbyte), .disconnect_evt(disc),
        .scsi_byte_valid(sbv), .host_byte_valid(hbv), .host_byte(hbyte), .host_par(hpar),
        .latch_evt(lev), .irq(irq));

    ssf_scsi_model i_ssf_scsi_model (
        .rst_req(rreq), .sel_req(sreq), .byte_on(bon), .byte_val(bval), .bad_par(bad),
        .bsy_o(bsy_o), .bsy_oe(bsy_oe), .data_o(data_o), .data_oe(data_oe),
        .rst_o(rst_o), .rst_oe(rst_oe), .bus(bus));

    // ----
    // Tasks and expectations
    // ----
    function automatic logic odd(input logic [7:0] b);
        return ~^b;
    endfunction

    function automatic logic [31:0] st2(input logic [5:0] f, input logic r, input logic p);
        return {24'h0, f, r, p};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge clk);
        awa <= a;
        wd <= {24'h0, d};
        {awv, wv, bry} <= 3'h7;
        do begin
            @(posedge clk);
            if (awv && awr) awv <= 0;
            if (wv && wrd) wv <= 0;
        end while (!(bvld && bry));
        bry <= 0;
        chk(32'(bresp), 32'(er));
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        ara <= a;
        {arv, rry} <= 2'h3;
        do begin
            @(posedge clk);
            if (arv && arr) arv <= 0;
        end while (!(rvld && rry));
        rry <= 0;
        d = rdata;
        r = rresp;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axr(a, d, r);
        chk(d, e);
        chk(32'(r), 32'(OK));
    endtask

    // Pulse vector: disconnect, scsi byte, host byte, message, then latch events
    task automatic pulse(input logic [9:0] v);
        @(posedge clk);
        {disc, sbv, hbv, mv, lev} <= v;
        @(posedge clk);
        {disc, sbv, hbv, mv, lev} <= 10'h000;
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            print_verdict();
        end
    end

    // ----
    // Tests
    // ----
    logic [10:0] dtab [5] = '{11'h604, 11'h600, 11'h707, 11'h504, 11'h004};
    logic [8:0]  ltab [6] = '{9'h104, 9'h046, 9'h025, 9'h081, 9'h008, 9'h011};
    logic [7:0]  hc [4] = '{8'h08, 8'h0c, 8'h00, 8'h08};
    logic [31:0] d;
    logic [1:0]  r;

    initial begin
        void'($urandom(32'hb00487d5));
        repeat (8) @(posedge clk);
        nrst <= 1;
        rd(`SSF_OFS_STAT0, 32'h0);
        rd(`SSF_OFS_STAT1, 32'h0);
        axw(8'h20, 8'h00, ERR);
        axr(8'h20, d, r);
        chk(32'(r), 32'(ERR));
        $display("test reset and map done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {rreq, bad, bon} <= {i[0], 1'($urandom), 1'b1};
            bval <= 8'($urandom);
            @(posedge clk);
            rd(`SSF_OFS_STAT1, st2(6'h00, i[0], odd(bval) ^ bad));
        end
        rd(`SSF_OFS_STAT0, 32'h2);
        rd(`SSF_OFS_STAT0, 32'h0);
        rreq <= 0;
        axw(`SSF_OFS_CTRL1, 8'h08, OK);
        // Reset drive is registered one cycle after the control write lands
        @(posedge clk);
        chkb(bus.rst, 1'b1);
        rd(`SSF_OFS_STAT0, 32'h2);
        axw(`SSF_OFS_CTRL1, 8'h00, OK);
        repeat (2) @(posedge clk);
        chkb(irq, 1'b0);
        axw(`SSF_OFS_IMSK, 8'h02, OK);
        repeat (2) @(posedge clk);
        chkb(irq, 1'b1);
        axw(`SSF_OFS_IST, 8'h1f, OK);
        repeat (2) @(posedge clk);
        chkb(irq, 1'b0);
        rd(`SSF_OFS_IST, 32'h0);
        $display("test bus reset done");
        for (int i = 0; i < 4; i++) begin
            axw(`SSF_OFS_CTRL0, {4'h0, i[1], 3'h0}, OK);
            bval <= 8'($urandom);
            bad <= i[0];
            pulse(10'h100);
            rd(`SSF_OFS_STAT0, {31'h0, i[1] & i[0]});
        end
        bon <= 0;
        for (int i = 0; i < 4; i++) begin
            axw(`SSF_OFS_CTRL0, hc[i], OK);
            hbyte <= 8'($urandom);
            @(posedge clk);
            hpar <= odd(hbyte) ^ (i < 3);
            pulse(10'h080);
            rd(`SSF_OFS_STAT0, {31'h0, i == 0});
        end
        $display("test parity done");
        foreach (dtab[i]) begin
            {init, scr} <= dtab[i][10:9];
            mbyte <= dtab[i][7:0];
            pulse(10'h040);
            pulse(10'h200);
            rd(`SSF_OFS_STAT0, {29'h0, dtab[i][8], 2'h0});
        end
        $display("test disconnect done");
        foreach (ltab[i]) begin
            pulse({4'h0, ltab[i][8:3]});
            rd(`SSF_OFS_STAT1, st2({ltab[i][2:0], 3'h0}, 1'b0, 1'b0));
        end
        axw(`SSF_OFS_STAT0, 8'hff, OK);
        axw(`SSF_OFS_STAT1, 8'hff, OK);
        rd(`SSF_OFS_STAT1, st2(6'h08, 1'b0, 1'b0));
        pulse(10'h001);
        $display("test latches done");
        axw(`SSF_OFS_CTRL0, 8'hc0, OK);
        axw(`SSF_OFS_CTRL1, 8'h31, OK);
        repeat (10) @(posedge clk);
        chkb(bsy_oe & data_oe & data_o[3] & bus.bsy, 1'b1);
        rd(`SSF_OFS_STAT1, st2(6'h04, 1'b0, 1'b0));
        repeat (320) @(posedge clk);
        rd(`SSF_OFS_STAT1, st2(6'h01, 1'b0, 1'b0));
        axw(`SSF_OFS_CTRL1, 8'h31, OK);
        repeat (10) @(posedge clk);
        sreq <= 1;
        repeat (3) @(posedge clk);
        sreq <= 0;
        rd(`SSF_OFS_STAT1, st2(6'h02, 1'b0, 1'b0));
        chkb(bsy_oe, 1'b0);
        axw(`SSF_OFS_CTRL0, 8'h40, OK);
        axw(`SSF_OFS_CTRL1, 8'h31, OK);
        repeat (330) @(posedge clk);
        rd(`SSF_OFS_STAT1, 32'h0);
        $display("test arbitration done");
        print_verdict();
    end
endmodule
